// [logic/psb_pkg.sv]
`default_nettype none
package psb_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] PSB_SIDEBAND_OFF = 5'h19;
  localparam logic [4:0] PSB_XOVER_OFF = 5'h1b;
  // ==========================================================
  // Sideband register fields
  localparam int PSB_SB_EN_POS = 0;
  localparam int PSB_SEL0_LSB = 1;
  localparam int PSB_SEL1_LSB = 4;
  localparam int PSB_SEL_W = 3;
  localparam logic [15:0] PSB_SIDEBAND_RST = 16'h0000;
  // ==========================================================
  // Crossover register fields
  localparam int PSB_MANUAL_PAIR_SWAP_POS = 8;
  localparam int PSB_AMDIX_POS = 9;
  localparam int PSB_RISE_LSB = 10;
  localparam int PSB_RISE_W = 2;
  // ==========================================================
  // Status item codes on the receive data bits
  localparam logic [2:0] PSB_ST_LINK = 3'h0;
  localparam logic [2:0] PSB_ST_SPEED = 3'h1;
  localparam logic [2:0] PSB_ST_DUPLEX = 3'h2;
  localparam logic [2:0] PSB_ST_ANEG = 3'h3;
  localparam logic [2:0] PSB_ST_POLREV = 3'h4;
  localparam logic [2:0] PSB_ST_JABBER = 3'h5;
  localparam logic [2:0] PSB_ST_INTPEND = 3'h6;
  localparam logic [2:0] PSB_ST_RSVD = 3'h7;
  localparam int PSB_NUM_ITEMS = 7;
endpackage
`default_nettype wire

// [logic/psb_status_if.sv]
`default_nettype none
// ==========================================================
// Link status items passed to the selectors
interface psb_status_if;
  logic [6:0] item;
  modport src (output item);
  modport sink (input item);
endinterface
`default_nettype wire

// [logic/psb_sel_mux.sv]
`default_nettype none
// ==========================================================
// One status selector for one receive data bit
module psb_sel_mux
  import psb_pkg::*;
(
  input wire logic [2:0] sel,   // Status code
  psb_status_if.sink st,        // Status items
  output logic bit_o            // Selected status
);
  // Code 111 is reserved and shows zero
  always_comb begin
    if (sel == PSB_ST_RSVD) begin
      bit_o = 1'b0;
    end else begin
      bit_o = st.item[sel];
    end
  end
endmodule
`default_nettype wire

// [logic/psb_regs.sv]
// Functional notes
// - Enable bit set puts the two selected status items on receive data bits between frames.
// - Bits 3:1 pick status for bit 0; codes link..interrupt, 111 reserved.
// - Bits 6:4 pick status for bit 1 with the same codes.
// - Isolate mode suppresses sideband status whatever the enable bit says.
// - Enable bit clear, its reset value, leaves no sideband status on data bits.
// - Crossover bit 9 turns automatic pair selection on or off.
// - Bit 8 manual pairs: 0 transmit A receive B, 1 the reverse.
// - Manual pair bit is ignored while automatic crossover is enabled.
`default_nettype none
module psb_regs
  import psb_pkg::*;
(
  input wire logic mclk,              // Management clock
  input wire logic sys_rst,           // Async reset, active high
  input wire logic [4:0] mgmt_addr,   // Register address
  input wire logic mgmt_wr,           // Write strobe
  input wire logic [15:0] mgmt_wdata, // Write data
  input wire logic mgmt_rd,           // Read strobe
  output logic [15:0] mgmt_rdata,     // Read data, one cycle after strobe
  input wire logic isolate,           // Control bit 0.10
  input wire logic st_link,           // Link up
  input wire logic st_speed,          // 100 Mbps
  input wire logic st_duplex,         // Full duplex
  input wire logic st_aneg_done,      // Autonegotiation complete
  input wire logic st_pol_rev,        // Polarity reversed
  input wire logic st_jabber,         // Jabber detected
  input wire logic st_int_pend,       // Interrupt pending
  input wire logic rx_crs_dv,         // Receive datapath carrier/valid
  input wire logic [1:0] rx_data_in,  // Receive datapath data bits
  output logic [1:0] rmii_rxd,        // RMII receive data to the MAC
  input wire logic [1:0] cfg_rise,    // Rise time strap
  input wire logic cfg_amdix,         // Auto crossover strap
  input wire logic cfg_manual_pair_swap,          // Manual pair strap
  input wire logic auto_pair_swap,    // Pair choice of the auto crossover
  output logic auto_crossover_enable, // Auto crossover running
  output logic pair_swap,             // 1: transmit B receive A
  output logic [1:0] rise_time_sel    // Rise time trim
);
  // ==========================================================
  // State
  typedef struct packed {
    logic sideband_status_enable;
    logic [2:0] rxd0_status_select;
    logic [2:0] rxd1_status_select;
    logic [1:0] rise;
    logic amdix;
    logic manual_pair_swap;
    logic strap_done;
    logic [15:0] rdata;
    logic [1:0] rxd;
    logic swap;
  } psb_state_t;

  psb_state_t s_q;
  psb_state_t s_d;
  logic oob_rxd0_status_select;
  logic oob_rxd1_status_select;
  logic oob_on;
  logic [15:0] sb_word;
  logic [15:0] xo_word;

  // ==========================================================
  // Status selectors
  psb_status_if st_if ();
  assign st_if.item = {st_int_pend, st_jabber, st_pol_rev, st_aneg_done,
                       st_duplex, st_speed, st_link};

  psb_sel_mux u_sel0 (
    .sel(s_q.rxd0_status_select),
    .st(st_if.sink),
    .bit_o(oob_rxd0_status_select)
  );

  psb_sel_mux u_sel1 (
    .sel(s_q.rxd1_status_select),
    .st(st_if.sink),
    .bit_o(oob_rxd1_status_select)
  );

  // Sideband allowed only when enabled and not isolated
  assign oob_on = s_q.sideband_status_enable && !isolate;

  // Register read images, reserved bits zero
  assign sb_word = {9'h000, s_q.rxd1_status_select, s_q.rxd0_status_select,
                    s_q.sideband_status_enable};
  assign xo_word = {4'h0, s_q.rise, s_q.amdix, s_q.manual_pair_swap, 8'h00};

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (!s_q.strap_done) begin
      // First edge after reset release catches the straps
      s_d.rise = cfg_rise;
      s_d.amdix = cfg_amdix;
      s_d.manual_pair_swap = cfg_manual_pair_swap;
      s_d.strap_done = 1'b1;
    end else if (mgmt_wr) begin
      if (mgmt_addr == PSB_SIDEBAND_OFF) begin
        s_d.sideband_status_enable = mgmt_wdata[PSB_SB_EN_POS];
        s_d.rxd0_status_select = mgmt_wdata[PSB_SEL0_LSB +: PSB_SEL_W];
        s_d.rxd1_status_select = mgmt_wdata[PSB_SEL1_LSB +: PSB_SEL_W];
      end else if (mgmt_addr == PSB_XOVER_OFF) begin
        s_d.rise = mgmt_wdata[PSB_RISE_LSB +: PSB_RISE_W];
        s_d.amdix = mgmt_wdata[PSB_AMDIX_POS];
        s_d.manual_pair_swap = mgmt_wdata[PSB_MANUAL_PAIR_SWAP_POS];
      end
    end
    // Read data, unmapped addresses read zero
    if (mgmt_rd) begin
      if (mgmt_addr == PSB_SIDEBAND_OFF) begin
        s_d.rdata = sb_word;
      end else if (mgmt_addr == PSB_XOVER_OFF) begin
        s_d.rdata = xo_word;
      end else begin
        s_d.rdata = 16'h0000;
      end
    end
    // Frame data passes; between frames sideband or zero
    if (rx_crs_dv) begin
      s_d.rxd = rx_data_in;
    end else if (oob_on) begin
      s_d.rxd = {oob_rxd1_status_select, oob_rxd0_status_select};
    end else begin
      s_d.rxd = 2'b00;
    end
    // Manual pair only counts with auto crossover off
    if (s_q.amdix) begin
      s_d.swap = auto_pair_swap;
    end else begin
      s_d.swap = s_q.manual_pair_swap;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign mgmt_rdata = s_q.rdata;
  assign rmii_rxd = s_q.rxd;
  assign auto_crossover_enable = s_q.amdix;
  assign pair_swap = s_q.swap;
  assign rise_time_sel = s_q.rise;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_oob_rxd0_status_select_link: assert property (
    (s_q.sideband_status_enable && !isolate && !rx_crs_dv &&
     s_q.rxd0_status_select == PSB_ST_LINK) |=> rmii_rxd[0] == $past(st_link))
    else $error("sideband bit 0 does not show link");
  a_oob_rsvd_code: assert property (
    (oob_on && !rx_crs_dv && s_q.rxd0_status_select == PSB_ST_RSVD)
    |=> rmii_rxd[0] == 1'b0)
    else $error("reserved code shows nonzero");
  a_oob_rxd1_status_select_speed: assert property (
    (oob_on && !rx_crs_dv && s_q.rxd1_status_select == PSB_ST_SPEED)
    |=> rmii_rxd[1] == $past(st_speed))
    else $error("sideband bit 1 does not show speed");
  a_oob_isolate_off: assert property (
    (isolate && !rx_crs_dv) |=> rmii_rxd == 2'b00)
    else $error("sideband active while isolated");
  a_oob_disabled: assert property (
    (!s_q.sideband_status_enable && !rx_crs_dv) |=> rmii_rxd == 2'b00)
    else $error("sideband active while disabled");
  a_auto_write: assert property (
    (s_q.strap_done && mgmt_wr && mgmt_addr == PSB_XOVER_OFF)
    |=> auto_crossover_enable == $past(mgmt_wdata[PSB_AMDIX_POS]))
    else $error("auto crossover bit not written");
  a_manual_pair: assert property (
    (!s_q.amdix && $stable(s_q.manual_pair_swap))
    |=> pair_swap == $past(s_q.manual_pair_swap))
    else $error("manual pair not applied");
  a_auto_overrides: assert property (
    s_q.amdix |=> pair_swap == $past(auto_pair_swap))
    else $error("manual pair used under auto crossover");
  a_strap_load: assert property (
    !s_q.strap_done |=> (rise_time_sel == $past(cfg_rise) &&
                         auto_crossover_enable == $past(cfg_amdix)) ##1 s_q.strap_done)
    else $error("straps not caught after reset");

  a_sb_enable_write: assert property (
    (s_q.strap_done && mgmt_wr && mgmt_addr == PSB_SIDEBAND_OFF)
    |=> s_q.sideband_status_enable == $past(mgmt_wdata[PSB_SB_EN_POS]))
    else $error("sideband enable bit not written");
  a_frame_wins: assert property (
    rx_crs_dv |=> rmii_rxd == $past(rx_data_in))
    else $error("frame data not passed to receive bits");
  a_read_sel_image: assert property (
    (mgmt_rd && mgmt_addr == PSB_SIDEBAND_OFF)
    |=> (mgmt_rdata[PSB_SEL0_LSB +: PSB_SEL_W] == $past(s_q.rxd0_status_select) &&
         mgmt_rdata[PSB_SEL1_LSB +: PSB_SEL_W] == $past(s_q.rxd1_status_select)))
    else $error("select fields read back wrong");
  a_manual_write: assert property (
    (s_q.strap_done && mgmt_wr && mgmt_addr == PSB_XOVER_OFF)
    |=> s_q.manual_pair_swap == $past(mgmt_wdata[PSB_MANUAL_PAIR_SWAP_POS]))
    else $error("manual pair bit not written");
  a_rise_write: assert property (
    (s_q.strap_done && mgmt_wr && mgmt_addr == PSB_XOVER_OFF)
    |=> rise_time_sel == $past(mgmt_wdata[PSB_RISE_LSB +: PSB_RISE_W]))
    else $error("rise time field not written");
  a_manual_pair_swap_strap: assert property (
    !s_q.strap_done |=> s_q.manual_pair_swap == $past(cfg_manual_pair_swap))
    else $error("manual pair strap not caught");
  a_strap_no_write: assert property (
    !s_q.strap_done |=> (!s_q.sideband_status_enable &&
                         s_q.rxd0_status_select == 3'h0 &&
                         s_q.rxd1_status_select == 3'h0))
    else $error("write taken on strap edge");

  c_oob_shown: cover property (oob_on && !rx_crs_dv ##1 rmii_rxd != 2'b00);
  c_strap_edge: cover property (!s_q.strap_done ##1 s_q.strap_done);
  c_isolate_hit: cover property (s_q.sideband_status_enable && isolate);
  c_auto_swap: cover property (s_q.amdix && auto_pair_swap ##1 pair_swap);
endmodule
`default_nettype wire

// [bench/psb_mac_model.sv]
`default_nettype none
// ==========================================================
// MAC side of the RMII receive bus
module psb_mac_model (
  input wire logic mclk,      // Reference clock
  input wire logic [1:0] rxd, // RMII receive data
  output logic [1:0] seen_q   // Last sampled pair
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sample on every rising edge, as a receiver does
  always_ff @(posedge mclk) begin
    seen_q <= rxd;
  end
endmodule
`default_nettype wire

// [bench/phy_sideband_and_crossover_regs_bench.sv]
`default_nettype none
// ==========================================================
// Self-checking bench
module phy_sideband_and_crossover_regs_bench;
  import psb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, wr, rd, iso, crs, aps, amdix_o, swap_o, cfg_a, cfg_m;
  logic [4:0] addr;
  logic [15:0] wdata, rdata;
  logic [6:0] st;
  logic [1:0] rxin, rxd, seen, rise_o, cfg_r;
  logic [2:0] c2;
  int error_cnt, n_compared;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
  // Clock
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  psb_regs uut (.mclk(mclk), .sys_rst(sys_rst), .mgmt_addr(addr), .mgmt_wr(wr),
    .mgmt_wdata(wdata), .mgmt_rd(rd), .mgmt_rdata(rdata), .isolate(iso),
    .st_link(st[0]), .st_speed(st[1]), .st_duplex(st[2]), .st_aneg_done(st[3]),
    .st_pol_rev(st[4]), .st_jabber(st[5]), .st_int_pend(st[6]), .rx_crs_dv(crs),
    .rx_data_in(rxin), .rmii_rxd(rxd), .cfg_rise(cfg_r), .cfg_amdix(cfg_a),
    .cfg_manual_pair_swap(cfg_m), .auto_pair_swap(aps), .auto_crossover_enable(amdix_o),
    .pair_swap(swap_o), .rise_time_sel(rise_o));
  psb_mac_model mac (.mclk(mclk), .rxd(rxd), .seen_q(seen));
  // ==========================================================
  // Shared tasks
  task summarize;
    $display("Counts: %0d compared, %0d errors", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Strobe for one edge, then let an idle edge pass
  task wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(posedge mclk);
    #1 wr = 0;
    @(posedge mclk);
    #1;
  endtask
  task rd_reg(input logic [4:0] a);
    addr = a;
    rd = 1;
    @(posedge mclk);
    #1 rd = 0;
    @(posedge mclk);
    #1;
  endtask
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rd_reg(PSB_SIDEBAND_OFF);
    `CHK(rdata, PSB_SIDEBAND_RST)
    rd_reg(PSB_XOVER_OFF);
    `CHK(rdata, 16'h0900)
    `CHK({rise_o, amdix_o, swap_o}, 4'h9)
    `CHK(seen, 2'h0)
    rd_reg(5'h1a);
    `CHK(rdata, 16'h0000)
    wr_reg(5'h1a, 16'h0001);
    rd_reg(PSB_SIDEBAND_OFF);
    `CHK(rdata, PSB_SIDEBAND_RST)
    $display("t_reset done");
  endtask
  task t_codes;
    for (int c = 0; c < 8; c++) begin
      c2 = 3'(c + 1);
      wr_reg(PSB_SIDEBAND_OFF, {9'h000, c2, 3'(c), 1'b1});
      settle();
      `CHK(seen[0], (c == 7) ? 1'b0 : st[c])
      `CHK(seen[1], (c2 == 3'h7) ? 1'b0 : st[c2])
      rd_reg(PSB_SIDEBAND_OFF);
      `CHK(rdata, {9'h000, c2, 3'(c), 1'b1})
    end
    crs = 1;
    rxin = 2'h2;
    settle();
    `CHK(seen, 2'h2)
    crs = 0;
    $display("t_codes done");
  endtask
  task t_iso;
    wr_reg(PSB_SIDEBAND_OFF, 16'h0011);
    settle();
    `CHK(seen, 2'h3)
    iso = 1;
    settle();
    `CHK(seen, 2'h0)
    iso = 0;
    wr_reg(PSB_SIDEBAND_OFF, 16'h0010);
    settle();
    `CHK(seen, 2'h0)
    $display("t_iso done");
  endtask
  task t_xover;
    wr_reg(PSB_XOVER_OFF, 16'h0c00);
    settle();
    `CHK({rise_o, amdix_o, swap_o}, 4'hc)
    wr_reg(PSB_XOVER_OFF, 16'h0100);
    settle();
    `CHK({amdix_o, swap_o}, 2'h1)
    aps = 1;
    wr_reg(PSB_XOVER_OFF, 16'h0200);
    settle();
    `CHK({amdix_o, swap_o}, 2'h3)
    aps = 0;
    wr_reg(PSB_XOVER_OFF, 16'h0300);
    settle();
    `CHK({amdix_o, swap_o}, 2'h2)
    rd_reg(PSB_XOVER_OFF);
    `CHK(rdata, 16'h0300)
    $display("t_xover done");
  endtask
  // Second reset with other strap levels
  task t_strap;
    cfg_r = 2'h1;
    cfg_a = 1'b1;
    cfg_m = 1'b0;
    aps = 1;
    sys_rst = 1;
    #1;
    `CHK({rdata, rxd}, 18'h00000)
    `CHK({rise_o, amdix_o, swap_o}, 4'h0)
    repeat (2) @(posedge mclk);
    #1 sys_rst = 0;
    @(posedge mclk);
    #1;
    `CHK({rise_o, amdix_o}, 3'h3)
    rd_reg(PSB_XOVER_OFF);
    `CHK(rdata, 16'h0600)
    `CHK(swap_o, 1'b1)
    rd_reg(PSB_SIDEBAND_OFF);
    `CHK(rdata, PSB_SIDEBAND_RST)
    $display("t_strap done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1;
    {wr, rd, iso, crs, aps, addr, wdata, rxin} = '0;
    st = 7'b1010011;
    cfg_r = 2'h2;
    cfg_a = 1'b0;
    cfg_m = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 0;
    @(posedge mclk);
    #1;
    t_reset();
    t_codes();
    t_iso();
    t_xover();
    t_strap();
    summarize();
  end
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
